// ---- tx_protect_pkg.sv ----
// package: register map, field positions, reset values and counts for the transmit protection bank
package tx_protect_pkg;
    localparam int          ADDR_W        = 12;
    localparam int          DATA_W        = 8;
    localparam int          NUM_DP        = 2;
    localparam int          SAMPLE_W      = 16;
    localparam int          SAMPLE_MSBS   = 6;
    localparam int          POWER_W       = 13;
    localparam int          SHORT_AVG_LOG2 = 2;
    localparam int          FLUSH_CYCLES  = 16;

    localparam logic [11:0] PAGE_ADDR     = 12'h008;
    localparam logic [11:0] PWR_LSB_ADDR  = 12'h58B;
    localparam logic [11:0] PWR_MSB_ADDR  = 12'h58C;
    localparam logic [11:0] SM_ADDR       = 12'h58D;
    localparam logic [11:0] OVR_ADDR      = 12'h596;
    localparam logic [11:0] IRQ_LO_ADDR   = 12'h597;
    localparam logic [11:0] IRQ_HI_ADDR   = 12'h598;
    localparam logic [11:0] FLUSH_ADDR    = 12'h599;
    localparam logic [11:0] BOOT_ADDR     = 12'h705;
    localparam logic [11:0] LOOP_PD_ADDR  = 12'h790;

    localparam int          SM_ON_BIT     = 0;
    localparam int          SW_OVR_BIT    = 2;
    localparam int          SW_VAL_BIT    = 3;
    localparam int          IRQ_HI_BIT    = 0;
    localparam int          FLUSH_EN_BIT  = 0;
    localparam int          BOOT_GO_BIT   = 0;

    // protection event positions inside the nine-bit enable vector
    localparam int          IRQ_CGS       = 8;
    localparam int          IRQ_FRAME_SYNC = 7;
    localparam int          IRQ_CHECKSUM  = 6;
    localparam int          IRQ_LANE_SYNC = 5;
    localparam int          IRQ_DESKEW    = 4;
    localparam int          IRQ_DISPARITY = 3;
    localparam int          IRQ_NOT_IN_TABLE = 2;
    localparam int          IRQ_UNEXP_K   = 1;
    localparam int          IRQ_LANE_FIFO = 0;

    localparam logic [7:0]  PAGE_RST      = 8'h03;
    localparam logic [7:0]  SM_RST        = 8'h02;
    localparam logic [7:0]  IRQ_LO_RST    = 8'h00;
    localparam logic        IRQ_HI_RST    = 1'b0;
    localparam logic        FLUSH_EN_RST  = 1'b1;
    localparam logic [7:0]  LOOP_PD_RST   = 8'h02;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_TX    = 3'b010,
        ST_FLUSH = 3'b100
    } tx_state_t;
endpackage

// ---- power_if.sv ----
// interface: sample feed into and average power back from one short-window averager
`timescale 1ns/1ps
interface power_if;
    logic                                     sample_valid;
    logic [tx_protect_pkg::SAMPLE_MSBS-1:0]   i_msb;
    logic [tx_protect_pkg::SAMPLE_MSBS-1:0]   q_msb;
    logic [tx_protect_pkg::POWER_W-1:0]       power;

    modport src (output sample_valid, output i_msb, output q_msb, input power);
    modport avg (input sample_valid, input i_msb, input q_msb, output power);
endinterface

// ---- short_power_avg.sv ----
// short-window average of i squared plus q squared over the sample msbs
`timescale 1ns/1ps
module short_power_avg #(
    parameter int AVG_LOG2 = tx_protect_pkg::SHORT_AVG_LOG2
) (
    input  wire logic sys_clk_in,
    input  wire logic resetn_in,
    power_if.avg      pwr
);
    import tx_protect_pkg::*;

    localparam int ACC_W = POWER_W + AVG_LOG2;

    logic [ACC_W-1:0]    acc;
    logic [AVG_LOG2-1:0] cnt;
    logic [POWER_W-1:0]  power;

    function automatic logic [11:0] square6(input logic [5:0] v);
        logic signed [11:0] p;
        // widen both operands first so the product is never formed at six bits
        p = 12'($signed(v)) * 12'($signed(v));
        return p;
    endfunction

    // only the six msbs enter, so the sum fits 13 bits with headroom
    wire logic [POWER_W-1:0] inst_power = 13'(square6(pwr.i_msb)) + 13'(square6(pwr.q_msb));
    wire logic               last       = (cnt == {AVG_LOG2{1'b1}});

    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            acc   <= '0;
            cnt   <= '0;
            power <= '0;
        end else if (pwr.sample_valid) begin
            cnt <= cnt + 1'b1;
            acc <= last ? '0 : acc + ACC_W'(inst_power);
            if (last) begin
                power <= POWER_W'((acc + ACC_W'(inst_power)) >> AVG_LOG2);
            end
        end
    end

    assign pwr.power = power;

    a_power_range: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        power <= 13'h0800) else $error("average power above the six-bit maximum");
endmodule

// ---- tx_protect_ctrl_regs.sv ----
// top: paged transmit protection control registers with transmit-enable state machines
`timescale 1ns/1ps
module tx_protect_ctrl_regs #(
    parameter int NDP          = tx_protect_pkg::NUM_DP,
    parameter int FLUSH_LEN    = tx_protect_pkg::FLUSH_CYCLES
) (
    input  wire logic                                      sys_clk_in,
    input  wire logic                                      resetn_in,
    input  wire logic [tx_protect_pkg::ADDR_W-1:0]         reg_addr_in,
    input  wire logic                                      reg_wr_in,
    input  wire logic                                      reg_rd_in,
    input  wire logic [tx_protect_pkg::DATA_W-1:0]         reg_wdata_in,
    output logic      [tx_protect_pkg::DATA_W-1:0]         reg_rdata_out,
    output logic                                           reg_rvalid_out,
    input  wire logic [NDP-1:0][tx_protect_pkg::SAMPLE_W-1:0] i_sample_in,
    input  wire logic [NDP-1:0][tx_protect_pkg::SAMPLE_W-1:0] q_sample_in,
    input  wire logic [NDP-1:0]                            sample_valid_in,
    input  wire logic [NDP-1:0]                            transmit_enable_input_in,
    output logic      [NDP-1:0]                            tx_status_out,
    output logic      [NDP-1:0]                            tx_active_out,
    output logic      [NDP-1:0]                            flush_out,
    output logic      [8:0]                                link_protect_irq_enables_out,
    output logic                                           boot_loader_go_out,
    input  wire logic                                      boot_done_in,
    input  wire logic                                      boot_fail_in,
    output logic                                           boot_busy_out,
    output logic      [7:0]                                loop_powerdown_out
);
    import tx_protect_pkg::*;

    localparam int CNT_W = $clog2(FLUSH_LEN + 1);

    logic [NDP-1:0]             page_mask;
    logic [7:1]                 sm_spare;
    logic [NDP-1:0]             tx_state_machine_on;
    logic [NDP-1:0]             sw_transmit_value;
    logic [NDP-1:0]             sw_transmit_override_on;
    logic [NDP-1:0]             flush_on;
    logic [7:0]                 irq_lo;
    logic                       irq_hi;
    logic                       boot_loader_go;
    logic [7:0]                 loop_pd;
    tx_state_t                  state      [NDP];
    tx_state_t                  next_state [NDP];
    logic [CNT_W-1:0]           flush_cnt  [NDP];
    logic [POWER_W-1:0]         short_avg_power [NDP];
    logic [DATA_W-1:0]          next_rdata;

    // lowest selected datapath answers reads; all selected ones take writes
    function automatic int first_sel(input logic [NDP-1:0] mask);
        int idx;
        idx = 0;
        for (int k = NDP - 1; k >= 0; k--) begin
            if (mask[k]) begin
                idx = k;
            end
        end
        return idx;
    endfunction

    wire logic wr_page  = reg_wr_in && (reg_addr_in == PAGE_ADDR);
    wire logic wr_sm    = reg_wr_in && (reg_addr_in == SM_ADDR);
    wire logic wr_ovr   = reg_wr_in && (reg_addr_in == OVR_ADDR);
    wire logic wr_irqlo = reg_wr_in && (reg_addr_in == IRQ_LO_ADDR);
    wire logic wr_irqhi = reg_wr_in && (reg_addr_in == IRQ_HI_ADDR);
    wire logic wr_flush = reg_wr_in && (reg_addr_in == FLUSH_ADDR);
    wire logic wr_boot  = reg_wr_in && (reg_addr_in == BOOT_ADDR);
    wire logic wr_lpd   = reg_wr_in && (reg_addr_in == LOOP_PD_ADDR);
    wire logic boot_set = wr_boot && reg_wdata_in[BOOT_GO_BIT];
    // a net must be four-state, so the selected index is an integer, not an int
    wire integer sel    = first_sel(page_mask);

    // transmit status source per datapath
    wire logic [NDP-1:0] tx_src = (sw_transmit_override_on & sw_transmit_value) |
                                  (~sw_transmit_override_on & transmit_enable_input_in);

    // averagers, one per main datapath
    for (genvar d = 0; d < NDP; d++) begin : g_pwr
        power_if pif ();
        assign pif.sample_valid = sample_valid_in[d];
        assign pif.i_msb = i_sample_in[d][SAMPLE_W-1 -: SAMPLE_MSBS];
        assign pif.q_msb = q_sample_in[d][SAMPLE_W-1 -: SAMPLE_MSBS];
        assign short_avg_power[d] = pif.power;
        short_power_avg u_avg (
            .sys_clk_in (sys_clk_in),
            .resetn_in  (resetn_in),
            .pwr        (pif)
        );
    end

    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            page_mask <= NDP'(PAGE_RST);
            sm_spare  <= SM_RST[7:1];
            irq_lo    <= IRQ_LO_RST;
            irq_hi    <= IRQ_HI_RST;
            loop_pd   <= LOOP_PD_RST;
        end else begin
            if (wr_page) begin
                page_mask <= reg_wdata_in[NDP-1:0];
            end
            if (wr_sm) begin
                sm_spare <= reg_wdata_in[7:1];
            end
            if (wr_irqlo) begin
                irq_lo <= reg_wdata_in;
            end
            if (wr_irqhi) begin
                irq_hi <= reg_wdata_in[IRQ_HI_BIT];
            end
            if (wr_lpd) begin
                loop_pd <= reg_wdata_in;
            end
        end
    end

    // paged copies: a write lands only in the datapaths the page mask selects
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            tx_state_machine_on     <= '0;
            sw_transmit_value       <= '0;
            sw_transmit_override_on <= '0;
            flush_on                <= {NDP{FLUSH_EN_RST}};
        end else begin
            for (int d = 0; d < NDP; d++) begin
                if (page_mask[d] && wr_sm) begin
                    tx_state_machine_on[d] <= reg_wdata_in[SM_ON_BIT];
                end
                if (page_mask[d] && wr_ovr) begin
                    sw_transmit_value[d]       <= reg_wdata_in[SW_VAL_BIT];
                    sw_transmit_override_on[d] <= reg_wdata_in[SW_OVR_BIT];
                end
                if (page_mask[d] && wr_flush) begin
                    flush_on[d] <= reg_wdata_in[FLUSH_EN_BIT];
                end
            end
        end
    end

    // a flush, once begun, runs its full length even if transmit comes back; clearing the machine enable cuts it short
    always_comb begin
        for (int d = 0; d < NDP; d++) begin
            next_state[d] = state[d];
            case (state[d])
                ST_IDLE:  if (tx_src[d]) next_state[d] = ST_TX;
                ST_TX:    if (!tx_src[d]) next_state[d] = flush_on[d] ? ST_FLUSH : ST_IDLE;
                ST_FLUSH: if (flush_cnt[d] == CNT_W'(FLUSH_LEN - 1)) next_state[d] = ST_IDLE;
                default:  next_state[d] = ST_IDLE;
            endcase
            if (!tx_state_machine_on[d]) begin
                next_state[d] = ST_IDLE;
            end
        end
    end

    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            for (int d = 0; d < NDP; d++) begin
                state[d]     <= ST_IDLE;
                flush_cnt[d] <= '0;
            end
            tx_status_out <= '0;
            tx_active_out <= '0;
            flush_out     <= '0;
        end else begin
            for (int d = 0; d < NDP; d++) begin
                state[d]     <= next_state[d];
                flush_cnt[d] <= (state[d] == ST_FLUSH) ? flush_cnt[d] + 1'b1 : '0;
                // with the machine off the status passes straight through, unprotected
                tx_active_out[d] <= tx_state_machine_on[d] ? (next_state[d] == ST_TX) : tx_src[d];
                flush_out[d]     <= (next_state[d] == ST_FLUSH);
            end
            tx_status_out <= tx_src;
        end
    end

    // software start wins over a completion arriving in the same cycle
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            boot_loader_go     <= 1'b0;
            boot_loader_go_out <= 1'b0;
            boot_busy_out      <= 1'b0;
        end else begin
            if (boot_set) begin
                boot_loader_go <= 1'b1;
            end else if (boot_done_in || boot_fail_in) begin
                boot_loader_go <= 1'b0;
            end
            boot_loader_go_out <= boot_set;
            boot_busy_out      <= boot_loader_go;
        end
    end

    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            link_protect_irq_enables_out <= '0;
            loop_powerdown_out           <= LOOP_PD_RST;
        end else begin
            link_protect_irq_enables_out[IRQ_CGS]        <= irq_hi;
            link_protect_irq_enables_out[IRQ_FRAME_SYNC:IRQ_LANE_FIFO] <= irq_lo;
            // power-down bits are only driven out; bypass policy is software's
            loop_powerdown_out <= loop_pd;
        end
    end

    // read decode; unmapped and reserved bits return zero
    always_comb begin
        next_rdata = '0;
        if (reg_addr_in == PAGE_ADDR) begin
            next_rdata = 8'(page_mask);
        end else if (reg_addr_in == PWR_LSB_ADDR) begin
            next_rdata = short_avg_power[sel][7:0];
        end else if (reg_addr_in == PWR_MSB_ADDR) begin
            next_rdata = {3'h0, short_avg_power[sel][12:8]};
        end else if (reg_addr_in == SM_ADDR) begin
            next_rdata = {sm_spare, tx_state_machine_on[sel]};
        end else if (reg_addr_in == OVR_ADDR) begin
            next_rdata = {4'h0, sw_transmit_value[sel], sw_transmit_override_on[sel], 2'h0};
        end else if (reg_addr_in == IRQ_LO_ADDR) begin
            next_rdata = irq_lo;
        end else if (reg_addr_in == IRQ_HI_ADDR) begin
            next_rdata = {7'h00, irq_hi};
        end else if (reg_addr_in == FLUSH_ADDR) begin
            next_rdata = {7'h00, flush_on[sel]};
        end else if (reg_addr_in == BOOT_ADDR) begin
            next_rdata = {7'h00, boot_loader_go};
        end else if (reg_addr_in == LOOP_PD_ADDR) begin
            next_rdata = loop_pd;
        end
    end

    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            reg_rdata_out  <= '0;
            reg_rvalid_out <= 1'b0;
        end else begin
            reg_rdata_out  <= reg_rd_in ? next_rdata : '0;
            reg_rvalid_out <= reg_rd_in;
        end
    end

    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!resetn_in);

    a_sm_off_noflush: assert property (!tx_state_machine_on[0] |=> !flush_out[0] && tx_active_out[0] == $past(tx_src[0]))
        else $error("state machine acted while disabled");
    a_override_value: assert property (sw_transmit_override_on[0] |=> tx_status_out[0] == $past(sw_transmit_value[0]))
        else $error("override did not select software value");
    a_pin_value: assert property (!sw_transmit_override_on[0] |=> tx_status_out[0] == $past(transmit_enable_input_in[0]))
        else $error("status not taken from pin");
    a_flush_gated: assert property (!flush_on[0] && state[0] != ST_FLUSH |=> !flush_out[0])
        else $error("flush while flush disabled");
    a_flush_length: assert property ($rose(flush_out[0]) |-> ##[15:17] !flush_out[0])
        else $error("flush length wrong");
    a_boot_start: assert property (boot_set |=> boot_loader_go && boot_loader_go_out)
        else $error("boot loader did not start");
    a_boot_clear: assert property (!boot_set && boot_loader_go && (boot_done_in || boot_fail_in) |=> !boot_loader_go)
        else $error("boot loader bit did not self clear");
    a_irq_high_map: assert property (wr_irqhi |=> ##1 link_protect_irq_enables_out[IRQ_CGS] == $past(reg_wdata_in[0], 2))
        else $error("cgs enable misplaced");
    a_reserved_zero: assert property (reg_rvalid_out && $past(reg_addr_in) == OVR_ADDR |-> reg_rdata_out[7:4] == 4'h0 && reg_rdata_out[1:0] == 2'h0)
        else $error("reserved bits not zero");
    a_page_guard: assert property (wr_sm && !page_mask[0] |=> tx_state_machine_on[0] == $past(tx_state_machine_on[0]))
        else $error("unselected page written");
    a_power_msb: assert property (reg_rvalid_out && $past(reg_addr_in) == PWR_MSB_ADDR |-> reg_rdata_out[7:5] == 3'h0)
        else $error("power high byte reserved bits set");

    c_flush_seen: cover property ($rose(flush_out[0]));
    c_boot_done: cover property (boot_loader_go && boot_done_in);
    c_override_on: cover property (sw_transmit_override_on[0] && tx_status_out[0]);
endmodule

// ---- tx_protect_ctrl_regs_bench.sv ----
// testbench: register access, paging, transmit state machine, boot loader and power readback
`timescale 1ns/1ps
module tx_protect_ctrl_regs_bench;
    import tx_protect_pkg::*;
    logic                   sys_clk_in = 1'b0;
    logic                   resetn_in  = 1'b0;
    logic [11:0]            addr       = 12'h000;
    logic                   wr         = 1'b0;
    logic                   rd         = 1'b0;
    logic [7:0]             wdata      = 8'h00;
    logic [7:0]             rdata;
    logic                   rvalid;
    logic [1:0][15:0]       i_smp      = '0;
    logic [1:0][15:0]       q_smp      = '0;
    logic [1:0]             smp_vld    = 2'b00;
    logic [1:0]             txen_pin   = 2'b00;
    logic [1:0]             tx_status, tx_active, flush;
    logic [8:0]             irq_en;
    logic                   boot_go, boot_busy;
    logic                   boot_done  = 1'b0;
    logic                   boot_fail  = 1'b0;
    logic [7:0]             loop_pd;
    logic [7:0]             d;
    int                     error_cnt  = 0;
    int                     num_checks = 0;
    int                     go_cnt     = 0;
    int                     flush_cnt;

    tx_protect_ctrl_regs #(.NDP(2), .FLUSH_LEN(16)) dut (
        .sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .reg_addr_in(addr), .reg_wr_in(wr),
        .reg_rd_in(rd), .reg_wdata_in(wdata), .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
        .i_sample_in(i_smp), .q_sample_in(q_smp), .sample_valid_in(smp_vld),
        .transmit_enable_input_in(txen_pin), .tx_status_out(tx_status), .tx_active_out(tx_active),
        .flush_out(flush), .link_protect_irq_enables_out(irq_en), .boot_loader_go_out(boot_go),
        .boot_done_in(boot_done), .boot_fail_in(boot_fail), .boot_busy_out(boot_busy),
        .loop_powerdown_out(loop_pd));

    always #4 sys_clk_in = ~sys_clk_in;
    always @(posedge sys_clk_in) if (boot_go === 1'b1) go_cnt <= go_cnt + 1;

    task automatic step(input int n);
        repeat (n) @(posedge sys_clk_in);
        #1;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    // one-cycle write strobe, then one idle cycle so strobes never meet in one time step
    task automatic reg_write(input logic [11:0] a, input logic [7:0] v);
        addr  = a;
        wdata = v;
        wr    = 1'b1;
        step(1);
        wr    = 1'b0;
        step(1);
    endtask

    // bounded wait for the registered read answer
    task automatic reg_read(input logic [11:0] a, output logic [7:0] v);
        int k;
        addr = a;
        rd   = 1'b1;
        for (k = 0; k < 4; k++) begin
            step(1);
            rd = 1'b0;
            if (rvalid === 1'b1) break;
        end
        if (k == 4) begin
            error_cnt++;
            print_verdict();
        end
        v = rdata;
        step(1);
    endtask

    task automatic pin_cycle(output int cnt);
        txen_pin = 2'b01;
        step(4);
        check(tx_active, 2'b01);
        txen_pin = 2'b00;
        cnt = 0;
        repeat (30) begin
            step(1);
            if (flush[0] === 1'b1) cnt++;
        end
    endtask

    logic [11:0] t_addr [10] = '{12'h008, 12'h58D, 12'h596, 12'h597, 12'h598, 12'h599, 12'h705,
                                 12'h790, 12'h58C, 12'h123};
    logic [7:0]  t_rst  [10] = '{8'h03, 8'h02, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h02, 8'h00, 8'h00};
    logic [11:0] r_addr [4]  = '{12'h596, 12'h598, 12'h599, 12'h705};
    logic [7:0]  r_wr   [4]  = '{8'hF3, 8'hFE, 8'hFE, 8'hFE};

    initial begin
        step(4);
        resetn_in = 1'b1;
        // reset values, an unmapped address among them
        foreach (t_addr[k]) begin
            reg_read(t_addr[k], d);
            check(d, t_rst[k]);
        end
        check(flush, 2'b00);
        $display("test reset values done");

        // reserved bits ignore writes
        foreach (r_addr[k]) begin
            reg_write(r_addr[k], r_wr[k]);
            reg_read(r_addr[k], d);
            check(d, 8'h00);
        end
        reg_write(FLUSH_ADDR, 8'h01);
        $display("test reserved bits done");

        // each protection enable lands on its own output bit
        for (int b = 0; b < 9; b++) begin
            reg_write(IRQ_LO_ADDR, (b < 8) ? (8'h01 << b) : 8'h00);
            reg_write(IRQ_HI_ADDR, (b == 8) ? 8'h01 : 8'h00);
            step(1);
            check(irq_en, 9'h001 << b);
        end
        reg_read(IRQ_HI_ADDR, d);
        check(d, 8'h01);
        $display("test protection enables done");

        // override written through page 0 only
        reg_write(PAGE_ADDR, 8'h01);
        reg_write(OVR_ADDR, 8'h0C);
        step(1);
        check(tx_status, 2'b01);
        reg_read(OVR_ADDR, d);
        check(d, 8'h0C);
        reg_write(PAGE_ADDR, 8'h02);
        reg_read(OVR_ADDR, d);
        check(d, 8'h00);
        reg_write(PAGE_ADDR, 8'h01);
        reg_write(OVR_ADDR, 8'h04);
        step(1);
        check(tx_status, 2'b00);
        reg_write(OVR_ADDR, 8'h00);
        reg_write(PAGE_ADDR, 8'h03);
        $display("test override and paging done");

        // machine off: status passes through, never flushes
        txen_pin = 2'b01;
        step(3);
        check(tx_status, 2'b01);
        check(tx_active, 2'b01);
        txen_pin = 2'b00;
        step(3);
        check(flush, 2'b00);
        // machine on: flush runs its full length on disable
        reg_write(SM_ADDR, 8'h03);
        pin_cycle(flush_cnt);
        check(flush_cnt, 16);
        check(tx_active, 2'b00);
        // flush disabled: straight back to idle
        reg_write(FLUSH_ADDR, 8'h00);
        pin_cycle(flush_cnt);
        check(flush_cnt, 0);
        reg_write(FLUSH_ADDR, 8'h01);
        reg_write(SM_ADDR, 8'h02);
        $display("test state machine done");

        // boot loader start, ended once by done and once by fail
        for (int k = 0; k < 2; k++) begin
            reg_write(BOOT_ADDR, 8'h01);
            reg_read(BOOT_ADDR, d);
            check(d, 8'h01);
            check(boot_busy, 1'b1);
            boot_done = (k == 0);
            boot_fail = (k == 1);
            step(1);
            boot_done = 1'b0;
            boot_fail = 1'b0;
            step(2);
            reg_read(BOOT_ADDR, d);
            check(d, 8'h00);
        end
        check(go_cnt, 2);
        $display("test boot loader done");

        // loop power-down written as for a bypassed loop
        reg_write(LOOP_PD_ADDR, 8'hFF);
        step(1);
        check(loop_pd, 8'hFF);
        reg_read(LOOP_PD_ADDR, d);
        check(d, 8'hFF);
        $display("test loop power-down done");

        // full-scale negative msbs: 32*32 + 32*32 = 0x800
        i_smp   = {16'h8000, 16'h8000};
        q_smp   = {16'h83FF, 16'h83FF};
        smp_vld = 2'b11;
        step(4);
        smp_vld = 2'b00;
        step(3);
        reg_read(PWR_LSB_ADDR, d);
        check(d, 8'h00);
        reg_read(PWR_MSB_ADDR, d);
        check(d, 8'h08);
        $display("test power readback done");
        print_verdict();
    end
endmodule
